/* File: logic/rxs_pkg.sv */
`default_nettype none
package rxs_pkg;
    typedef enum logic [1:0] {
        RXS_MODE_CONT   = 2'b00,
        RXS_MODE_BUFF   = 2'b01,
        RXS_MODE_PKT0   = 2'b10,
        RXS_MODE_PKT1   = 2'b11
    } rxs_mode_e;

    typedef struct packed {
        logic [7:0] floor;
        logic [3:0] step_half_db;
        logic [2:0] rate_code;
        logic       rate_faster;
        logic       cutoff_wide;
    } rxs_onoff_s;

    typedef struct packed {
        logic [3:0] lowpass_bandwidth_code;
        logic [3:0] rx_bandwidth_code;
        logic [3:0] polyphase_center_code;
        logic       polyphase_active;
        logic       bitsync_bypass;
    } rxs_front_s;
endpackage
`default_nettype wire

/* File: logic/rxs_regs.svh */
`ifndef RXS_REGS_SVH
`define RXS_REGS_SVH
// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define RXS_IDX_FILTER_BW     8'h10
`define RXS_IDX_POLY_CENTER   8'h11
`define RXS_IDX_SYNC_CONTROL  8'h12
`define RXS_IDX_THRESH_FLOOR  8'h13
`define RXS_IDX_SIGNAL_STR    8'h14
`define RXS_IDX_THRESH_DYN    8'h15
`define RXS_IDX_PATTERN3      8'h16
`define RXS_IDX_PATTERN2      8'h17
`define RXS_IDX_PATTERN1      8'h18
`define RXS_IDX_PATTERN0      8'h19
`define RXS_IDX_DATA_CONTROL  8'h30
`define RXS_IDX_IRQ_STATUS    8'h31
`define RXS_IDX_IRQ_MASK      8'h32
// ****************************************
// Reset values
// ****************************************
`define RXS_RST_FILTER_BW     8'hA3
`define RXS_RST_POLY_CENTER   8'h38
`define RXS_RST_SYNC_CONTROL  8'h18
`define RXS_RST_THRESH_FLOOR  8'h04
`define RXS_RST_THRESH_DYN    8'h00
`define RXS_RST_PATTERN       8'h00
`define RXS_RST_DATA_CONTROL  8'h00
// ****************************************
// Field positions
// ****************************************
`define RXS_BIT_POLY_EN       7
`define RXS_BIT_BITSYNC_OFF   6
`define RXS_BIT_SYNC_ON       5
`define RXS_BIT_FILL_METHOD   7
`define RXS_BIT_FILL          6
`define RXS_IRQ_SYNC          0
`define RXS_IRQ_FILL          1
`define RXS_PAT_MAX           6'd32
`define RXS_RESP_OKAY         2'b00
`define RXS_RESP_SLVERR       2'b10
`endif

/* File: logic/rxs_rx_config.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rxs_regs.svh"

module rxs_rx_config #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Receive side
    input  wire logic              rx_bit,
    input  wire logic              rx_bit_valid,
    input  wire logic              ook_mode,
    input  wire logic [7:0]        signal_strength_in,
    // Configuration and status out
    output rxs_pkg::rxs_front_s    front_cfg,
    output rxs_pkg::rxs_onoff_s    onoff_cfg,
    output rxs_pkg::rxs_mode_e     data_mode,
    output logic                   sync_detect,
    output logic                   fill_active,
    output logic                   irq
);

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0]  filter_bw_q;
    logic [7:0]  poly_center_q;
    logic [7:0]  sync_ctrl_q;
    logic [7:0]  floor_q;
    logic [7:0]  strength_q;
    logic [7:0]  dyn_q;
    logic [7:0]  pat3_q;
    logic [7:0]  pat2_q;
    logic [7:0]  pat1_q;
    logic [7:0]  pat0_q;
    logic [7:0]  data_ctrl_q;
    logic [1:0]  irq_status_q;
    logic [1:0]  irq_mask_q;
    logic [31:0] shift_q;
    logic [5:0]  seen_q;
    logic        detect_q;
    logic        fill_q;
    logic        irq_q;
    logic        poly_q;
    logic        bypass_q;
    logic [3:0]  step_q;
    logic        cutoff_q;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [5:0] popcount32(input logic [31:0] v);
        logic [5:0] n;
        n = 6'd0;
        for (int i = 0; i < 32; i++) begin
            n = n + {5'd0, v[i]};
        end
        return n;
    endfunction

    function automatic logic [3:0] step_units(input logic [2:0] code);
        logic [3:0] u;
        u = 4'd0;
        if (code[2]) begin
            u = {1'b0, code[1:0], 1'b0} + 4'd6;
        end else begin
            u = {2'b00, code[1:0]} + 4'd1;
        end
        return u;
    endfunction

    // ****************************************
    // AXI4-Lite write channel
    // ****************************************
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic              wstrb0_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              awready_q;
    logic              wready_q;

    wire aw_hs     = s_axi_awvalid && !aw_got_q && !bvalid_q;
    wire w_hs      = s_axi_wvalid && !w_got_q && !bvalid_q;
    wire wr_fire   = aw_got_q && w_got_q && !bvalid_q;
    // Next channel flags, so the readies can leave flops
    wire aw_got_d  = !wr_fire && (aw_hs || aw_got_q);
    wire w_got_d   = !wr_fire && (w_hs || w_got_q);
    wire bvalid_d  = wr_fire || (bvalid_q && !s_axi_bready);
    wire [7:0] widx = awaddr_q[9:2];
    wire wr_lane   = wr_fire && wstrb0_q;
    wire [7:0] wb  = wdata_q[7:0];

    wire wr_mapped = (widx >= `RXS_IDX_FILTER_BW && widx <= `RXS_IDX_PATTERN0)
                  || (widx >= `RXS_IDX_DATA_CONTROL && widx <= `RXS_IDX_IRQ_MASK);
    wire wr_ok_hit = wr_mapped && awaddr_q[ADDR_W-1:10] == '0;

    function automatic logic wsel(input logic [7:0] idx, input logic [7:0] want, input logic en);
        return en && idx == want;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= `RXS_RESP_OKAY;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
        end else begin
            awready_q <= !aw_got_d && !bvalid_d;
            wready_q  <= !w_got_d && !bvalid_d;
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_q  <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok_hit ? `RXS_RESP_OKAY : `RXS_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // ****************************************
    // AXI4-Lite read channel
    // ****************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        arready_q;

    wire       ar_hs = s_axi_arvalid && !rvalid_q;
    wire       rvalid_d = ar_hs || (rvalid_q && !s_axi_rready);
    wire [7:0] ridx  = s_axi_araddr[9:2];
    wire       r_hi0 = s_axi_araddr[ADDR_W-1:10] == '0;
    logic [7:0] rbyte;
    logic       rhit;

    always_comb begin
        rhit  = r_hi0;
        rbyte = 8'h00;
        case (ridx)
            `RXS_IDX_FILTER_BW:    rbyte = filter_bw_q;
            `RXS_IDX_POLY_CENTER:  rbyte = poly_center_q;
            `RXS_IDX_SYNC_CONTROL: rbyte = sync_ctrl_q;
            `RXS_IDX_THRESH_FLOOR: rbyte = floor_q;
            `RXS_IDX_SIGNAL_STR:   rbyte = strength_q;
            `RXS_IDX_THRESH_DYN:   rbyte = dyn_q;
            `RXS_IDX_PATTERN3:     rbyte = pat3_q;
            `RXS_IDX_PATTERN2:     rbyte = pat2_q;
            `RXS_IDX_PATTERN1:     rbyte = pat1_q;
            `RXS_IDX_PATTERN0:     rbyte = pat0_q;
            `RXS_IDX_DATA_CONTROL: rbyte = {data_ctrl_q[7], fill_q, 4'h0, data_ctrl_q[1:0]};
            `RXS_IDX_IRQ_STATUS:   rbyte = {6'h00, irq_status_q};
            `RXS_IDX_IRQ_MASK:     rbyte = {6'h00, irq_mask_q};
            default:               rhit  = 1'b0;
        endcase
    end

    // Reading the status register clears it
    wire status_rd = ar_hs && rhit && ridx == `RXS_IDX_IRQ_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RXS_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rhit ? {24'h00_0000, rbyte} : 32'h0000_0000;
            rresp_q  <= rhit ? `RXS_RESP_OKAY : `RXS_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
        end else begin
            arready_q <= !rvalid_d;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ****************************************
    // Configuration registers
    // ****************************************
    wire wr_en = wr_lane && wr_ok_hit;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filter_bw_q   <= `RXS_RST_FILTER_BW;
            poly_center_q <= `RXS_RST_POLY_CENTER;
            sync_ctrl_q   <= `RXS_RST_SYNC_CONTROL;
            floor_q       <= `RXS_RST_THRESH_FLOOR;
            dyn_q         <= `RXS_RST_THRESH_DYN;
            pat3_q        <= `RXS_RST_PATTERN;
            pat2_q        <= `RXS_RST_PATTERN;
            pat1_q        <= `RXS_RST_PATTERN;
            pat0_q        <= `RXS_RST_PATTERN;
            data_ctrl_q   <= `RXS_RST_DATA_CONTROL;
            irq_mask_q    <= 2'b00;
        end else begin
            if (wsel(widx, `RXS_IDX_FILTER_BW, wr_en))    filter_bw_q   <= wb;
            if (wsel(widx, `RXS_IDX_POLY_CENTER, wr_en))  poly_center_q <= wb;
            if (wsel(widx, `RXS_IDX_SYNC_CONTROL, wr_en)) sync_ctrl_q   <= wb;
            if (wsel(widx, `RXS_IDX_THRESH_FLOOR, wr_en)) floor_q       <= wb;
            if (wsel(widx, `RXS_IDX_THRESH_DYN, wr_en))   dyn_q         <= wb;
            if (wsel(widx, `RXS_IDX_PATTERN3, wr_en))     pat3_q        <= wb;
            if (wsel(widx, `RXS_IDX_PATTERN2, wr_en))     pat2_q        <= wb;
            if (wsel(widx, `RXS_IDX_PATTERN1, wr_en))     pat1_q        <= wb;
            if (wsel(widx, `RXS_IDX_PATTERN0, wr_en))     pat0_q        <= wb;
            if (wsel(widx, `RXS_IDX_DATA_CONTROL, wr_en)) data_ctrl_q   <= wb;
            if (wsel(widx, `RXS_IDX_IRQ_MASK, wr_en))     irq_mask_q    <= wb[1:0];
        end
    end

    // strength tracks the input, bus writes never land here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strength_q <= 8'h00;
        end else begin
            strength_q <= signal_strength_in;
        end
    end

    // ****************************************
    // Sync word recognizer
    // ****************************************
    wire       sync_on  = sync_ctrl_q[`RXS_BIT_SYNC_ON];
    wire [1:0] sync_sz  = sync_ctrl_q[4:3];
    wire [1:0] sync_tol = sync_ctrl_q[2:1];
    wire [31:0] shift_d = {shift_q[30:0], rx_bit};

    wire [5:0] pat_len = {1'b0, sync_sz, 3'b000} + 6'd8;

    // first byte is the MSB; unused bytes masked off
    logic [31:0] pat_val;
    logic [31:0] pat_mask;
    always_comb begin
        case (sync_sz)
            2'b00:   pat_val = {24'h00_0000, pat3_q};
            2'b01:   pat_val = {16'h0000, pat3_q, pat2_q};
            2'b10:   pat_val = {8'h00, pat3_q, pat2_q, pat1_q};
            default: pat_val = {pat3_q, pat2_q, pat1_q, pat0_q};
        endcase
        case (sync_sz)
            2'b00:   pat_mask = 32'h0000_00FF;
            2'b01:   pat_mask = 32'h0000_FFFF;
            2'b10:   pat_mask = 32'h00FF_FFFF;
            default: pat_mask = 32'hFFFF_FFFF;
        endcase
    end

    // count differing bits over the window
    wire [5:0] diff_cnt = popcount32((shift_d ^ pat_val) & pat_mask);
    wire [5:0] seen_inc = (seen_q == `RXS_PAT_MAX) ? seen_q : seen_q + 6'd1;
    // accept up to the tolerance in errors
    wire match_now = rx_bit_valid && sync_on && seen_inc >= pat_len
                  && diff_cnt <= {4'h0, sync_tol};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q  <= 32'h0000_0000;
            seen_q   <= 6'd0;
            detect_q <= 1'b0;
        end else begin
            detect_q <= match_now;
            if (!sync_on) begin
                seen_q <= 6'd0;
            end else if (rx_bit_valid) begin
                shift_q <= shift_d;
                // Rearm: a fresh full window is needed after a hit
                seen_q  <= match_now ? 6'd0 : seen_inc;
            end
        end
    end

    // ****************************************
    // Data path mode and buffer fill
    // ****************************************
    // mode field decode
    wire mode_cont   = data_ctrl_q[1:0] == 2'b00;
    wire mode_buff   = data_ctrl_q[1:0] == 2'b01;
    wire fill_manual = data_ctrl_q[`RXS_BIT_FILL_METHOD];
    wire ctrl_wr     = wsel(widx, `RXS_IDX_DATA_CONTROL, wr_en);
    wire fill_wr1    = ctrl_wr && wb[`RXS_BIT_FILL];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_q <= 1'b0;
        end else if (!mode_buff) begin
            fill_q <= 1'b0;
        end else if (fill_manual) begin
            if (ctrl_wr) fill_q <= wb[`RXS_BIT_FILL];
        // auto fill starts on a detected pattern, set beats clear
        end else if (detect_q) begin
            fill_q <= 1'b1;
        end else if (fill_wr1) begin
            fill_q <= 1'b0;
        end
    end

    // ****************************************
    // Front end controls
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            poly_q   <= 1'b0;
            bypass_q <= 1'b0;
        end else begin
            poly_q   <= ook_mode && sync_ctrl_q[`RXS_BIT_POLY_EN];
            // bypass only applies in continuous mode
            bypass_q <= mode_cont && sync_ctrl_q[`RXS_BIT_BITSYNC_OFF];
        end
    end

    // Decoded threshold fields held in flops; they lag the register by a cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_q   <= 4'h1;
            cutoff_q <= 1'b1;
        end else begin
            // step decode to half dB units
            step_q   <= step_units(dyn_q[7:5]);
            // reserved codes fall back to the wide corner
            cutoff_q <= dyn_q[1:0] != 2'b11;
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    wire fill_start = mode_buff && !fill_manual && detect_q && !fill_q;
    wire [1:0] irq_set = {fill_start, detect_q};

    // Set beats the clear-on-read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= 2'b00;
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= (status_rd ? 2'b00 : irq_status_q) | irq_set;
            irq_q        <= |(irq_status_q & irq_mask_q);
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign front_cfg.lowpass_bandwidth_code = filter_bw_q[7:4];
    assign front_cfg.rx_bandwidth_code      = filter_bw_q[3:0];
    assign front_cfg.polyphase_center_code  = poly_center_q[7:4];
    assign front_cfg.polyphase_active       = poly_q;
    assign front_cfg.bitsync_bypass         = bypass_q;
    assign onoff_cfg.floor        = floor_q;
    assign onoff_cfg.step_half_db = step_q;
    // rate code, top bit means several per chip
    assign onoff_cfg.rate_code    = dyn_q[4:2];
    assign onoff_cfg.rate_faster  = dyn_q[4];
    // only code 11 selects the narrow corner
    assign onoff_cfg.cutoff_wide  = cutoff_q;
    assign data_mode   = rxs_pkg::rxs_mode_e'(data_ctrl_q[1:0]);
    assign sync_detect = detect_q;
    assign fill_active = fill_q;
    assign irq         = irq_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_aw_w_taken;
        wr_fire;
    endsequence
    sequence s_resp_out;
        ##1 s_axi_bvalid;
    endsequence

    a_detect_needs_on: assert property (sync_detect |-> $past(sync_on))
        else $error("sync detect while recognition off");
    a_size_window: assert property (sync_detect |=> !sync_detect [*7])
        else $error("detect before a full new window");
    a_tol_bound: assert property (sync_detect |-> $past(diff_cnt) <= {4'h0, $past(sync_tol)})
        else $error("match exceeds tolerance");
    a_bypass_mode: assert property (##1 bypass_q == $past(mode_cont && sync_ctrl_q[6]))
        else $error("bypass not per mode");
    a_poly_ook: assert property (front_cfg.polyphase_active |-> $past(ook_mode))
        else $error("polyphase on outside OOK");
    a_strength_track: assert property (##1 strength_q == $past(signal_strength_in))
        else $error("strength not tracking");
    a_step_units: assert property (dyn_q[7:5] == 3'b111 |=> onoff_cfg.step_half_db == 4'd12)
        else $error("step decode wrong");
    a_fill_on_sync: assert property (detect_q && mode_buff && !fill_manual ##1 mode_buff |-> fill_q)
        else $error("auto fill missed sync");
    a_wr_resp: assert property (s_aw_w_taken |-> s_resp_out)
        else $error("write response late");
    a_irq_level: assert property (##2 irq == |($past(irq_status_q) & $past(irq_mask_q)))
        else $error("irq level mismatch");

endmodule
`default_nettype wire

/* File: tb/rxs_bit_source.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Received bit stream source
// ****
module rxs_bit_source (
    // Clock
    input  wire logic        aclk,
    // Control
    input  wire logic        go,
    input  wire logic [31:0] pat,
    input  wire logic [5:0]  len,
    // Stream
    output logic             rx_bit,
    output logic             rx_bit_valid
);
    logic [31:0] sh_q  = 32'h0000_0000;
    logic [5:0]  cnt_q = 6'h00;
    logic        tog_q = 1'b0;
    // earliest bit is the pattern MSB
    always_ff @(posedge aclk) begin
        tog_q <= ~tog_q;
        if (go) begin
            sh_q  <= pat;
            cnt_q <= len;
        end else if (cnt_q != 6'h00) begin
            sh_q  <= sh_q << 1;
            cnt_q <= cnt_q - 6'h01;
        end
    end
    assign rx_bit_valid = (cnt_q != 6'h00);
    // Idle line toggles so a stale bit never looks like data
    assign rx_bit = rx_bit_valid ? sh_q[31] : tog_q;
endmodule
`default_nettype wire

/* File: tb/test_rxs_rx_config.sv */
`timescale 1ns/10ps
`default_nettype none
module test_rxs_rx_config;
    logic                aclk, aresetn, go, rx_bit, rx_bit_valid, ook_mode;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready, sync_detect, fill_active, irq;
    logic [11:0]         awaddr, araddr;
    logic [31:0]         wdata, rdata, pat;
    logic [3:0]          wstrb;
    logic [1:0]          bresp, rresp;
    logic [5:0]          len;
    logic [7:0]          strength;
    rxs_pkg::rxs_front_s front_cfg;
    rxs_pkg::rxs_onoff_s onoff_cfg;
    rxs_pkg::rxs_mode_e  data_mode;
    int                  failures = 0;
    int                  checks   = 0;
    int                  hits     = 0;
    int                  exp_hits = 0;
    logic [7:0]          ridx [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                                       8'h16, 8'h17, 8'h18, 8'h19, 8'h30, 8'h32};
    logic [7:0]          rst  [12] = '{8'hA3, 8'h38, 8'h18, 8'h04, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [3:0]          stp  [8]  = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
    localparam logic [31:0] W = 32'hA53C_960F;

    rxs_rx_config i_rxs_rx_config (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .ook_mode(ook_mode),
        .signal_strength_in(strength), .front_cfg(front_cfg), .onoff_cfg(onoff_cfg),
        .data_mode(data_mode), .sync_detect(sync_detect), .fill_active(fill_active), .irq(irq)
    );
    rxs_bit_source i_rxs_bit_source (
        .aclk(aclk), .go(go), .pat(pat), .len(len), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (sync_detect === 1'b1)
            hits <= hits + 1;
    end

    // ****
    // Shared tasks
    // ****
    task automatic end_sim();
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic guard(input int n);
        if (n >= 200) begin
            failures++;
            $display("unexpected wait timeout at %0t", $time);
            end_sim();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Each access starts one edge late so no signal is driven twice in a step
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        n = 0;
        awaddr  <= {2'b00, i, 2'b00};
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 200);
        bready <= 1'b0;
        guard(n);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        n = 0;
        araddr  <= {2'b00, i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 200);
        rready <= 1'b0;
        guard(n);
        chk(rdata, {24'h00_0000, e});
        chk(32'(rresp), 32'(er));
    endtask
    task automatic send(input logic [31:0] p, input logic [5:0] l);
        int n;
        @(posedge aclk);
        n = 0;
        pat <= p;
        len <= l;
        go  <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rx_bit_valid && n < 200);
        guard(n);
        tick(3);
    endtask
    // Off then on clears the bit count, so a match can only land on the last bit
    task automatic cfg_sync(input logic [1:0] s, input logic [1:0] t);
        wr(8'h12, {3'b000, s, t, 1'b0}, 2'b00);
        wr(8'h12, {3'b001, s, t, 1'b0}, 2'b00);
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        {aresetn, go, ook_mode, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {awaddr, araddr, wdata, pat, len, strength} = 102'h0;
        wstrb = 4'hF;
        tick(12);
        aresetn <= 1'b1;
        for (int k = 0; k < 12; k++) rd(ridx[k], rst[k], 2'b00);
        chk(32'(front_cfg), 32'h0000_28CC);
        rd(8'h3F, 8'h00, 2'b10);
        wr(8'h3F, 8'h55, 2'b10);
        strength <= 8'h5A;
        wr(8'h13, 8'h04, 2'b00);
        rd(8'h14, 8'h5A, 2'b00);
        for (int k = 0; k < 8; k++) begin
            wr(8'h15, {3'(k), 3'(k), {2{k[0]}}}, 2'b00);
            tick(1);
            chk(32'(onoff_cfg.step_half_db), 32'(stp[k]));
            chk(32'(onoff_cfg.rate_code), 32'(k));
            chk(32'(onoff_cfg.rate_faster), 32'(k >= 4));
            chk(32'(onoff_cfg.cutoff_wide), 32'(k % 2 == 0));
        end
        wr(8'h13, 8'h7E, 2'b00);
        chk(32'(onoff_cfg.floor), 32'h0000_007E);
        ook_mode <= 1'b1;
        wr(8'h12, 8'hC0, 2'b00);
        tick(2);
        chk(32'(front_cfg.polyphase_active), 32'h0000_0001);
        chk(32'(front_cfg.bitsync_bypass), 32'h0000_0001);
        ook_mode <= 1'b0;
        wr(8'h30, 8'h01, 2'b00);
        tick(2);
        chk(32'(front_cfg.polyphase_active), 32'h0000_0000);
        chk(32'(front_cfg.bitsync_bypass), 32'h0000_0000);
        chk(32'(data_mode), 32'h0000_0001);
        wr(8'h30, 8'h02, 2'b00);
        chk(32'(data_mode), 32'h0000_0002);
        wr(8'h30, 8'h00, 2'b00);
        for (int k = 0; k < 4; k++) wr(8'(8'h16 + k), 8'(W >> (24 - 8 * k)), 2'b00);
        wr(8'h12, 8'h18, 2'b00);
        send(W, 6'd32);
        chk(hits, exp_hits);
        for (int k = 0; k < 4; k++) begin
            cfg_sync(2'(k), 2'b00);
            send(W, 6'(8 * k + 8));
            exp_hits++;
            chk(hits, exp_hits);
        end
        // Errors one above and at the tolerance
        for (int k = 0; k < 4; k++) begin
            cfg_sync(2'b11, 2'(k));
            send(W ^ ((k < 2) ? 32'h0000_0001 : 32'h0000_0007), 6'd32);
            exp_hits += k % 2;
            chk(hits, exp_hits);
        end
        chk(32'(irq), 32'h0000_0000);
        wr(8'h32, 8'h01, 2'b00);
        tick(2);
        chk(32'(irq), 32'h0000_0001);
        rd(8'h31, 8'h01, 2'b00);
        tick(2);
        chk(32'(irq), 32'h0000_0000);
        rd(8'h31, 8'h00, 2'b00);
        wr(8'h30, 8'h01, 2'b00);
        cfg_sync(2'b00, 2'b00);
        send(W, 6'd8);
        chk(32'(fill_active), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        rd(8'h31, 8'h03, 2'b00);
        rd(8'h30, 8'h41, 2'b00);
        wr(8'h30, 8'h41, 2'b00);
        tick(2);
        chk(32'(fill_active), 32'h0000_0000);
        // Manual fill: method first, then the fill bit under it
        wr(8'h30, 8'h81, 2'b00);
        wr(8'h30, 8'hC1, 2'b00);
        chk(32'(fill_active), 32'h0000_0001);
        wr(8'h30, 8'h81, 2'b00);
        chk(32'(fill_active), 32'h0000_0000);
        end_sim();
    end
endmodule
`default_nettype wire
